//--- core/arcr_regs.svh
// arcr_regs.svh: register indices, field positions, resets and cell layout
// assumes: included by the arcr design files; APB byte address is index * 4
// Operation
// (RULE_01) payload-type top bit marks OAM; OAM select queues it or drops it
// (RULE_02) full queue at cell start drops the whole cell; bus never stalls
// (RULE_03) non-OAM cell needs all eight masked VPI bit checks to pass
// (RULE_04) mask 0 accepts the bit; mask 1 needs received bit equal match bit
// (RULE_05) after VPI passes, all sixteen masked VCI bit checks must pass
// (RULE_06) cells passing both filters enter the 32-cell queue
// (RULE_07) drained OAM cells go straight to data FIFO; others go to look-up
// (RULE_08) low VCI bits and low VPI bits form a zero-filled 15-bit index
// (RULE_09) two zero bits below the index give a 17-bit word-aligned offset
// (RULE_10) offset plus table base locates the 32-bit table entry
// (RULE_11) type 00 is unknown: dropped or stored as data by unknown select
// (RULE_12) type 01 is non-CBR: stored as 64-byte entry in data FIFO
// (RULE_13) type 10 is CBR: entry structure address fetches the control structure
// (RULE_14) OAM cells count as data only when control bit 5 is one
// (RULE_15) unknown cells count as data only when control bit 6 is set
// (RULE_16) data cell goes to FIFO base plus write pointer, structure address ignored
// (RULE_17) write pointer advances one entry after each stored data cell
// (RULE_18) host reads 24 words of a cell when write passes read pointer; the writer stores 26 halfwords per cell
// (RULE_19) no FIFO space: oldest cell is overwritten and status bit 10 set
// (RULE_20) write pointer wraps at region end; overrun compares with host read pointer
// (RULE_21) filters, index split and bases set before enable, then held
`ifndef ARCR_REGS_SVH
`define ARCR_REGS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define ARCR_IDX_CTRL      16'h4000
`define ARCR_IDX_STAT      16'h4002
`define ARCR_IDX_CONCAT    16'h4010
`define ARCR_IDX_VPI_MATCH 16'h4012
`define ARCR_IDX_VPI_MASK  16'h4014
`define ARCR_IDX_VCI_MATCH 16'h4016
`define ARCR_IDX_VCI_MASK  16'h4018
`define ARCR_IDX_LUT_BASE  16'h401E
`define ARCR_IDX_FIFO_BASE 16'h4020
`define ARCR_IDX_FIFO_WPTR 16'h4022
`define ARCR_IDX_FIFO_RPTR 16'h4024
`define ARCR_IDX_FIFO_SIZE 16'h4026

// ----------------------------------------
// fields and resets
// ----------------------------------------
`define ARCR_CTRL_RX_EN    0
`define ARCR_CTRL_OAM_SEL  5
`define ARCR_CTRL_UNK_SEL  6
`define ARCR_STAT_OVR      10
`define ARCR_CONCAT_N_LO   0
`define ARCR_CONCAT_M_LO   8
`define ARCR_RST_ZERO      16'h0000
`define ARCR_RST_FIFO_SIZE 16'h0040

// ----------------------------------------
// cell layout and table entry
// ----------------------------------------
`define ARCR_HEC_POS       6'h04
`define ARCR_CELL_LAST     6'h34
`define ARCR_LAST_WORD     6'h32
`define ARCR_T_UNKNOWN     2'h0
`define ARCR_T_NONCBR      2'h1
`define ARCR_T_CBR         2'h2

`endif

//--- core/arcr_pkg.sv
// arcr_pkg: types shared by the cell router
// assumes: constants come from arcr_regs.svh
package arcr_pkg;
    typedef enum logic [2:0] {
        DR_IDLE, DR_RD_HI, DR_RD_LO, DR_ASM, DR_LK_WAIT, DR_CBR_REQ, DR_CBR_WAIT, DR_WR_WAIT
    } arcr_dr_e;
    typedef logic [1:0] arcr_type_t;
endpackage : arcr_pkg

//--- core/arcr_sync.sv
// arcr_sync: two-flop synchroniser for pins from outside the pclk domain
// assumes: each bit is sampled independently; q is the second flop
module arcr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : arcr_sync

//--- core/arcr_cell_mem.sv
// arcr_cell_mem: byte store of the primary receive queue
// assumes: one write and one read port, read data one cycle after address
module arcr_cell_mem #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : arcr_cell_mem

//--- core/arcr_top.sv
// arcr_top: receive cell filter, primary queue, look-up engine and data FIFO writer
// assumes: utopia receive pins are passively tapped and asynchronous to pclk;
// external memory port is on pclk and answers each request with one ack pulse
//
// Our own choice: register access over APB.
`include "arcr_regs.svh"

module arcr_top
    import arcr_pkg::*;
#(
    parameter int QAW = 5
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // receive utopia tap
    input  wire logic        rx_clk,
    input  wire logic        rx_soc,
    input  wire logic        rx_enb_n,
    input  wire logic [7:0]  rx_data,
    // external memory
    output logic             mem_req,
    output logic             mem_we,
    output logic      [23:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // cbr hand-off
    output logic             cbr_valid,
    output logic      [23:0] cbr_struct_addr,
    output logic      [31:0] cbr_ctrl_word
);
    localparam logic [QAW:0] QDEPTH = (QAW+1)'(1 << QAW);

    // ----------------------------------------
    // pin synchronisation
    // ----------------------------------------
    logic [10:0] sy;
    logic        lclk_d_r;
    logic        byte_stb;

    arcr_sync #(.W(11)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({rx_clk, rx_enb_n, rx_soc, rx_data}),
        .q     (sy)
    );

    // falling link edge: mid-bit, away from data change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_d_r <= 1'b0;
        end else begin
            lclk_d_r <= sy[10];
        end
    end
    assign byte_stb = lclk_d_r & ~sy[10] & ~sy[9];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctrl_r, ctrl_nxt, concat_r, concat_nxt;
    logic [15:0] vpim_r, vpim_nxt, vpik_r, vpik_nxt;
    logic [15:0] vcim_r, vcim_nxt, vcik_r, vcik_nxt;
    logic [15:0] lut_r, lut_nxt, fbase_r, fbase_nxt;
    logic [15:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, fsize_r, fsize_nxt;
    logic        ovr_r, ovr_nxt, pready_nxt, pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic [15:0] ridx, rd, stat_w, wnext, rnext;
    logic        hit, wr, setup;
    logic        wptr_adv, ovr_set;
    logic [QAW:0] count_r;
    arcr_dr_e    st_r;

    assign ridx   = paddr[17:2];
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pready & pwrite;
    assign stat_w = {5'h00, ovr_r, 1'b0, st_r != DR_IDLE, 2'h0, (6)'(count_r)};
    assign wnext  = (wptr_r == fsize_r - 16'h0001) ? 16'h0000 : wptr_r + 16'h0001; // RULE_20
    assign rnext  = (rptr_r == fsize_r - 16'h0001) ? 16'h0000 : rptr_r + 16'h0001;

    always_comb begin
        rd  = 16'h0000;
        hit = (paddr[1:0] == 2'h0);
        case (ridx)
            `ARCR_IDX_CTRL:      rd = ctrl_r;
            `ARCR_IDX_STAT:      rd = stat_w;
            `ARCR_IDX_CONCAT:    rd = concat_r;
            `ARCR_IDX_VPI_MATCH: rd = vpim_r;
            `ARCR_IDX_VPI_MASK:  rd = vpik_r;
            `ARCR_IDX_VCI_MATCH: rd = vcim_r;
            `ARCR_IDX_VCI_MASK:  rd = vcik_r;
            `ARCR_IDX_LUT_BASE:  rd = lut_r;
            `ARCR_IDX_FIFO_BASE: rd = fbase_r;
            `ARCR_IDX_FIFO_WPTR: rd = wptr_r;
            `ARCR_IDX_FIFO_RPTR: rd = rptr_r;
            `ARCR_IDX_FIFO_SIZE: rd = fsize_r;
            default:             hit = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_nxt    = ctrl_r;
        concat_nxt  = concat_r;
        vpim_nxt    = vpim_r;
        vpik_nxt    = vpik_r;
        vcim_nxt    = vcim_r;
        vcik_nxt    = vcik_r;
        lut_nxt     = lut_r;
        fbase_nxt   = fbase_r;
        fsize_nxt   = fsize_r;
        wptr_nxt    = wptr_adv ? wnext : wptr_r; // RULE_17
        rptr_nxt    = ovr_set ? rnext : rptr_r; // RULE_19
        ovr_nxt     = ovr_r;
        pready_nxt  = setup;
        pslverr_nxt = setup & ~hit;
        prdata_nxt  = setup ? {16'h0000, rd} : prdata;
        if (wr && hit) begin
            case (ridx)
                `ARCR_IDX_CTRL:      ctrl_nxt = pwdata[15:0];
                `ARCR_IDX_STAT:      ovr_nxt = ovr_r & ~pwdata[`ARCR_STAT_OVR];
                `ARCR_IDX_CONCAT:    concat_nxt = pwdata[15:0];
                `ARCR_IDX_VPI_MATCH: vpim_nxt = pwdata[15:0];
                `ARCR_IDX_VPI_MASK:  vpik_nxt = pwdata[15:0];
                `ARCR_IDX_VCI_MATCH: vcim_nxt = pwdata[15:0];
                `ARCR_IDX_VCI_MASK:  vcik_nxt = pwdata[15:0];
                `ARCR_IDX_LUT_BASE:  lut_nxt = pwdata[15:0];
                `ARCR_IDX_FIFO_BASE: fbase_nxt = pwdata[15:0];
                `ARCR_IDX_FIFO_WPTR: wptr_nxt = pwdata[15:0];
                `ARCR_IDX_FIFO_RPTR: rptr_nxt = pwdata[15:0]; // RULE_18
                `ARCR_IDX_FIFO_SIZE: fsize_nxt = pwdata[15:0];
                default:             ctrl_nxt = ctrl_r;
            endcase
        end
        // a new overrun beats a clear in the same cycle
        if (ovr_set) begin
            ovr_nxt = 1'b1; // RULE_19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= `ARCR_RST_ZERO;
            concat_r <= `ARCR_RST_ZERO;
            vpim_r   <= `ARCR_RST_ZERO;
            vpik_r   <= `ARCR_RST_ZERO;
            vcim_r   <= `ARCR_RST_ZERO;
            vcik_r   <= `ARCR_RST_ZERO;
            lut_r    <= `ARCR_RST_ZERO;
            fbase_r  <= `ARCR_RST_ZERO;
            wptr_r   <= `ARCR_RST_ZERO;
            rptr_r   <= `ARCR_RST_ZERO;
            fsize_r  <= `ARCR_RST_FIFO_SIZE;
            ovr_r    <= 1'b0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            concat_r <= concat_nxt;
            vpim_r   <= vpim_nxt;
            vpik_r   <= vpik_nxt;
            vcim_r   <= vcim_nxt;
            vcik_r   <= vcik_nxt;
            lut_r    <= lut_nxt;
            fbase_r  <= fbase_nxt;
            wptr_r   <= wptr_nxt;
            rptr_r   <= rptr_nxt;
            fsize_r  <= fsize_nxt;
            ovr_r    <= ovr_nxt;
            pready   <= pready_nxt;
            pslverr  <= pslverr_nxt;
            prdata   <= prdata_nxt;
        end
    end

    // ----------------------------------------
    // cell capture and header filter
    // ----------------------------------------
    logic [5:0]   rx_pos_r, rx_pos_nxt;
    logic         rx_act_r, rx_act_nxt, rx_drop_r, rx_drop_nxt;
    logic [31:0]  rx_hdr_r, rx_hdr_nxt;
    logic [QAW-1:0] tail_r, tail_nxt, head_r;
    logic         mw_en, push, pop, q_full, rx_oam, vpi_ok, vci_ok, accept;
    logic [5:0]   mw_pos;

    assign q_full = (count_r == QDEPTH);
    assign rx_oam = rx_hdr_r[3]; // RULE_01
    // filters assumed stable while enabled
    assign vpi_ok = ((rx_hdr_r[27:20] ^ vpim_r[7:0]) & vpik_r[7:0]) == 8'h00; // RULE_03 RULE_04 RULE_21
    assign vci_ok = ((rx_hdr_r[19:4] ^ vcim_r) & vcik_r) == 16'h0000; // RULE_05 RULE_04
    assign accept = rx_oam ? ctrl_r[`ARCR_CTRL_OAM_SEL] : (vpi_ok & vci_ok); // RULE_01 RULE_14
    assign mw_pos = (rx_pos_r < `ARCR_HEC_POS) ? rx_pos_r : rx_pos_r - 6'h01;

    always_comb begin
        rx_pos_nxt  = rx_pos_r;
        rx_act_nxt  = rx_act_r;
        rx_drop_nxt = rx_drop_r;
        rx_hdr_nxt  = rx_hdr_r;
        mw_en       = 1'b0;
        push        = 1'b0;
        if (byte_stb) begin
            if (sy[8]) begin
                rx_act_nxt  = 1'b1;
                rx_pos_nxt  = 6'h01;
                // full queue drops the cell; tap never stalls
                rx_drop_nxt = q_full | ~ctrl_r[`ARCR_CTRL_RX_EN]; // RULE_02
                rx_hdr_nxt  = {24'h000000, sy[7:0]};
                mw_en       = ~(q_full | ~ctrl_r[`ARCR_CTRL_RX_EN]);
            end else if (rx_act_r) begin
                rx_pos_nxt = rx_pos_r + 6'h01;
                if (rx_pos_r < `ARCR_HEC_POS) begin
                    rx_hdr_nxt = {rx_hdr_r[23:0], sy[7:0]};
                end
                if (rx_pos_r != `ARCR_HEC_POS) begin
                    mw_en = ~rx_drop_r;
                end
                if (rx_pos_r == `ARCR_CELL_LAST) begin
                    rx_act_nxt = 1'b0;
                    push       = ~rx_drop_r & accept; // RULE_06
                end
            end
        end
        tail_nxt = tail_r + (QAW)'(push);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pos_r  <= 6'h00;
            rx_act_r  <= 1'b0;
            rx_drop_r <= 1'b0;
            rx_hdr_r  <= 32'h00000000;
            tail_r    <= '0;
            count_r   <= '0;
        end else begin
            rx_pos_r  <= rx_pos_nxt;
            rx_act_r  <= rx_act_nxt;
            rx_drop_r <= rx_drop_nxt;
            rx_hdr_r  <= rx_hdr_nxt;
            tail_r    <= tail_nxt;
            count_r   <= count_r + (QAW+1)'(push) - (QAW+1)'(pop);
        end
    end

    // ----------------------------------------
    // queue store
    // ----------------------------------------
    logic [5:0] pos_r, pos_nxt;
    logic [7:0] mrd;

    arcr_cell_mem #(.AW(QAW+6), .DW(8)) u_mem (
        .clk   (pclk),
        .we    (mw_en),
        .waddr ({tail_r, sy[8] ? 6'h00 : mw_pos}),
        .wdata (sy[7:0]),
        .raddr ({head_r, pos_r | {5'h00, st_r == DR_RD_LO}}),
        .rdata (mrd)
    );

    // ----------------------------------------
    // drain, look-up engine and data FIFO writer
    // ----------------------------------------
    function automatic logic [14:0] lut_index(input logic [7:0] vpi, input logic [15:0] vci,
                                              input logic [3:0] n, input logic [3:0] m);
        logic [31:0] a;
        logic [31:0] b;
        a = {16'h0000, vci} & ((32'h00000001 << n) - 32'h00000001);
        b = ({24'h000000, vpi} & ((32'h00000001 << m) - 32'h00000001)) << n;
        lut_index = (15)'(a | b); // RULE_08
    endfunction : lut_index

    arcr_dr_e    st_nxt;
    logic        wmode_r, wmode_nxt, cbr_valid_nxt;
    logic [7:0]  hi_r, hi_nxt;
    logic [31:0] hdr_r, hdr_nxt, hv, cbr_word_nxt;
    logic [15:0] word;
    logic        req_nxt, we_nxt;
    logic [23:0] addr_nxt, lut_a, fifo_a, cbr_addr_nxt;
    logic [15:0] wdata_nxt;
    logic [QAW-1:0] head_nxt;
    logic [14:0] idx;
    arcr_type_t  etype;

    assign word   = {hi_r, mrd};
    assign hv     = {hdr_r[31:16], word};
    assign idx    = lut_index(hv[27:20], hv[19:4], concat_r[`ARCR_CONCAT_N_LO +: 4],
                              concat_r[`ARCR_CONCAT_M_LO +: 4]);
    assign lut_a  = {lut_r, 8'h00} + {7'h00, idx, 2'b00}; // RULE_09 RULE_10
    assign fifo_a = {fbase_r, 8'h00} + {2'b00, wptr_r, 6'h00} + {18'h00000, pos_r}; // RULE_16
    assign etype  = mem_rdata[31:30];

    always_comb begin
        st_nxt        = st_r;
        pos_nxt       = pos_r;
        wmode_nxt     = wmode_r;
        hi_nxt        = hi_r;
        hdr_nxt       = hdr_r;
        head_nxt      = head_r;
        req_nxt       = mem_req;
        we_nxt        = mem_we;
        addr_nxt      = mem_addr;
        wdata_nxt     = mem_wdata;
        cbr_valid_nxt = 1'b0;
        cbr_addr_nxt  = cbr_struct_addr;
        cbr_word_nxt  = cbr_ctrl_word;
        pop           = 1'b0;
        wptr_adv      = 1'b0;
        ovr_set       = 1'b0;
        case (st_r)
            DR_IDLE: if (count_r != '0) begin
                pos_nxt   = 6'h00;
                wmode_nxt = 1'b0;
                st_nxt    = DR_RD_HI;
            end
            DR_RD_HI: st_nxt = DR_RD_LO;
            DR_RD_LO: begin
                hi_nxt = mrd;
                st_nxt = DR_ASM;
            end
            DR_ASM: if (wmode_r) begin
                req_nxt   = 1'b1;
                we_nxt    = 1'b1;
                addr_nxt  = fifo_a; // RULE_12 RULE_16
                wdata_nxt = word;
                st_nxt    = DR_WR_WAIT;
            end else if (pos_r == 6'h00) begin
                hdr_nxt[31:16] = word;
                pos_nxt        = 6'h02;
                st_nxt         = DR_RD_HI;
            end else begin
                hdr_nxt[15:0] = word;
                pos_nxt       = 6'h00;
                if (word[3]) begin
                    wmode_nxt = 1'b1; // RULE_07
                    st_nxt    = DR_RD_HI;
                end else begin
                    req_nxt  = 1'b1; // RULE_07
                    we_nxt   = 1'b0;
                    addr_nxt = lut_a;
                    st_nxt   = DR_LK_WAIT;
                end
            end
            DR_LK_WAIT: if (mem_ack) begin
                req_nxt = 1'b0;
                case (etype)
                    `ARCR_T_UNKNOWN: begin
                        wmode_nxt = ctrl_r[`ARCR_CTRL_UNK_SEL]; // RULE_11 RULE_15
                        pop       = ~ctrl_r[`ARCR_CTRL_UNK_SEL];
                        st_nxt    = ctrl_r[`ARCR_CTRL_UNK_SEL] ? DR_RD_HI : DR_IDLE;
                    end
                    `ARCR_T_NONCBR: begin
                        wmode_nxt = 1'b1; // RULE_12
                        st_nxt    = DR_RD_HI;
                    end
                    `ARCR_T_CBR: begin
                        cbr_addr_nxt = mem_rdata[23:0]; // RULE_13
                        st_nxt       = DR_CBR_REQ;
                    end
                    default: begin
                        pop    = 1'b1;
                        st_nxt = DR_IDLE;
                    end
                endcase
            end
            DR_CBR_REQ: if (pos_r == 6'h02) begin
                req_nxt  = 1'b1;
                we_nxt   = 1'b0;
                addr_nxt = cbr_struct_addr; // RULE_13
                st_nxt   = DR_CBR_WAIT;
            end else pos_nxt = pos_r + 6'h01;
            DR_CBR_WAIT: if (mem_ack) begin
                req_nxt       = 1'b0;
                cbr_valid_nxt = 1'b1;
                cbr_word_nxt  = mem_rdata;
                pop           = 1'b1;
                st_nxt        = DR_IDLE;
            end
            DR_WR_WAIT: if (mem_ack) begin
                req_nxt = 1'b0;
                we_nxt  = 1'b0;
                if (pos_r == `ARCR_LAST_WORD) begin
                    pop      = 1'b1;
                    wptr_adv = 1'b1; // RULE_17
                    // full region: oldest entry is dropped
                    ovr_set  = (wnext == rptr_r); // RULE_19 RULE_20
                    st_nxt   = DR_IDLE;
                end else begin
                    pos_nxt = pos_r + 6'h02;
                    st_nxt  = DR_RD_HI;
                end
            end
            default: st_nxt = DR_IDLE;
        endcase
        head_nxt = head_r + (QAW)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= DR_IDLE;
            pos_r           <= 6'h00;
            wmode_r         <= 1'b0;
            hi_r            <= 8'h00;
            hdr_r           <= 32'h00000000;
            head_r          <= '0;
            mem_req         <= 1'b0;
            mem_we          <= 1'b0;
            mem_addr        <= 24'h000000;
            mem_wdata       <= 16'h0000;
            cbr_valid       <= 1'b0;
            cbr_struct_addr <= 24'h000000;
            cbr_ctrl_word   <= 32'h00000000;
        end else begin
            st_r            <= st_nxt;
            pos_r           <= pos_nxt;
            wmode_r         <= wmode_nxt;
            hi_r            <= hi_nxt;
            hdr_r           <= hdr_nxt;
            head_r          <= head_nxt;
            mem_req         <= req_nxt;
            mem_we          <= we_nxt;
            mem_addr        <= addr_nxt;
            mem_wdata       <= wdata_nxt;
            cbr_valid       <= cbr_valid_nxt;
            cbr_struct_addr <= cbr_addr_nxt;
            cbr_ctrl_word   <= cbr_word_nxt;
        end
    end
endmodule : arcr_top

//--- sim/arcr_monitor.sv
// arcr_monitor: apb and memory port checks
// assumes: bound into arcr_top, pclk domain only
module arcr_monitor (
    // clock, reset, apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // memory and cbr
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_ack,
    input wire logic [23:0] mem_addr,
    input wire logic        cbr_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_pend; mem_req && !mem_ack; endsequence
    AST_RDY: assert property (s_setup |=> pready) else $error("ready late");
    AST_ONE: assert property (pready |=> !pready) else $error("ready long");
    AST_ERR: assert property (pslverr |-> pready) else $error("error alone");
    AST_HOLD: assert property (s_pend |=> mem_req && $stable(mem_addr)) else $error("req moved");
    AST_DROP: assert property (mem_req && mem_ack |=> !mem_req) else $error("req held");
    AST_GAP: assert property ($fell(mem_req) |-> !mem_req [*3]) else $error("gap short");
    AST_ALIGN: assert property (mem_req && !mem_we |-> mem_addr[1:0] == 2'h0)
        else $error("read unaligned");
    AST_CBR: assert property (cbr_valid |-> $past(mem_ack) && !$past(mem_we))
        else $error("cbr early");
endmodule : arcr_monitor

bind arcr_top arcr_monitor arcr_monitor_inst (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .mem_req, .mem_we, .mem_ack, .mem_addr, .cbr_valid);

//--- sim/arcr_phy.sv
// arcr_phy: receive phy cell source and external memory
// assumes: bench loads entry before each cell; every read returns entry
module arcr_phy (
    // clock
    input  wire logic        pclk,
    // utopia receive
    output logic             rx_clk,
    output logic             rx_soc,
    output logic             rx_enb_n,
    output logic [7:0]       rx_data,
    // memory
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [23:0] mem_addr,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] entry = 32'h0;
    logic [23:0] rd_addr;
    logic [23:0] wr_addr;
    int          n_wr = 0;
    initial begin
        {rx_clk, rx_soc, rx_data, mem_ack, mem_rdata} = '0;
        rx_enb_n = 1'h1;
    end
    wire         go = mem_req && !mem_ack;
    always @(posedge pclk) begin
        mem_ack   <= go;
        mem_rdata <= go ? entry : ~mem_rdata;
        if (go && !mem_we) rd_addr <= mem_addr;
        if (go && mem_we && n_wr == 0) wr_addr <= mem_addr;
        if (go && mem_we) n_wr <= n_wr + 1;
    end
    task automatic send_cell(input logic [31:0] hdr);
        for (int i = 0; i < 53; i++) begin
            rx_clk   = 1'h1;
            rx_data  = (i < 4) ? hdr[31 - 8 * i -: 8] : 8'(i);
            rx_soc   = (i == 0);
            rx_enb_n = 1'h0;
            #16 rx_clk = 1'h0;
            #16;
        end
        rx_enb_n = 1'h1;
        rx_data  = ~rx_data;
    endtask : send_cell
endmodule : arcr_phy

//--- sim/tb_arcr_top.sv
// tb_arcr_top: register and routing tests
// assumes: arcr_phy supplies cells and answers memory requests
`include "arcr_regs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_arcr_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        rx_clk, rx_soc, rx_enb_n, mem_req, mem_we, mem_ack, cbr_valid;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, mem_rdata, cbr_ctrl_word, r;
    logic [23:0] mem_addr, cbr_struct_addr;
    logic [15:0] mem_wdata;
    logic [7:0]  rx_data;
    int          failures = 0, n_tests = 0;
    // header, entry, wptr, halfwords
    logic [31:0] cells [6][4] = '{'{32'h8, 32'h0, 32'h1, 32'h1A},
        '{32'h05B00340, 32'h0, 32'h1, 32'h0}, '{32'h05A00350, 32'h0, 32'h1, 32'h0},
        '{32'h05A99340, 32'h40000000, 32'h2, 32'h1A}, '{32'h05A99340, 32'h0, 32'h2, 32'h0},
        '{32'h05A99340, 32'h80000100, 32'h2, 32'h0}};
    arcr_top arcr_top_inst (.*);
    arcr_phy arcr_phy_inst (.*);
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #100us;
        failures++;
        end_sim();
    end
    task automatic end_sim();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {i, 2'h0};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rdchk(input logic [15:0] i, input logic [31:0] m, input logic [31:0] ex);
        apb(1'h0, i, 32'h0);
        `CHK($sformatf("reg %0h", i), ex, r & m)
    endtask : rdchk
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdchk(`ARCR_IDX_FIFO_SIZE, 32'hFFFFFFFF, 32'h40);
        rdchk(`ARCR_IDX_CTRL, 32'hFFFFFFFF, 32'h0);
        apb(1'h0, 16'h4030, 32'h0);
        `CHK("unmapped error", 1'h1, e)
        $display("test reset done");
        apb(1'h1, `ARCR_IDX_VPI_MATCH, 32'h5A);
        apb(1'h1, `ARCR_IDX_VPI_MASK, 32'hFF);
        apb(1'h1, `ARCR_IDX_VCI_MATCH, 32'h34);
        apb(1'h1, `ARCR_IDX_VCI_MASK, 32'hFF);
        apb(1'h1, `ARCR_IDX_CONCAT, 32'h4);
        apb(1'h1, `ARCR_IDX_LUT_BASE, 32'h12);
        apb(1'h1, `ARCR_IDX_FIFO_BASE, 32'h30);
        apb(1'h1, `ARCR_IDX_FIFO_SIZE, 32'h4);
        apb(1'h1, `ARCR_IDX_CTRL, 32'h21);
        for (int k = 0; k < 6; k++) begin
            arcr_phy_inst.entry = cells[k][1];
            arcr_phy_inst.n_wr = 0;
            arcr_phy_inst.send_cell(cells[k][0]);
            repeat (300) @(posedge pclk);
            rdchk(`ARCR_IDX_FIFO_WPTR, 32'hFFFF, cells[k][2]);
            `CHK("halfwords", cells[k][3], 32'(arcr_phy_inst.n_wr))
            if (k == 4) `CHK("table addr", 24'h001210, arcr_phy_inst.rd_addr)
            $display("test cell %0d done", k);
        end
        `CHK("fifo addr", 24'h003040, arcr_phy_inst.wr_addr)
        `CHK("struct addr", 24'h000100, cbr_struct_addr)
        `CHK("struct word", 32'h80000100, cbr_ctrl_word)
        apb(1'h1, `ARCR_IDX_CTRL, 32'h61);
        arcr_phy_inst.entry = 32'h0;
        for (int k = 0; k < 2; k++) begin
            arcr_phy_inst.send_cell(cells[4][0]);
            repeat (300) @(posedge pclk);
        end
        rdchk(`ARCR_IDX_FIFO_WPTR, 32'hFFFF, 32'h0);
        rdchk(`ARCR_IDX_FIFO_RPTR, 32'hFFFF, 32'h1);
        rdchk(`ARCR_IDX_STAT, 32'h400, 32'h400);
        apb(1'h1, `ARCR_IDX_STAT, 32'h400);
        rdchk(`ARCR_IDX_STAT, 32'h400, 32'h0);
        $display("test overrun done");
        end_sim();
    end
endmodule : tb_arcr_top
